// File: tdtc_timer.v
// tdtc_timer.v: task driven up timer/counter with capture/compare slots
// assumes one 125 MHz clock; task inputs are one-cycle pulses on that clock
//
// What this block does
// [R1] tick and event modes, start and stop tasks
// [R2] counter only counts upward
// [R3] tick mode adds one per divided tick
// [R4] event mode counts count tasks, ignores divider
// [R5] count task ignored in tick mode
// [R6] width select sets highest counter value
// [R7] change divider and width only while halted
// [R8] overflow wraps to zero and keeps counting
// [R9] clear task forces counter to zero
// [R10] match only when increment hits slot value
// [R11] each slot has its own match event
// [R12] match compares only active width bits
// [R13] snapshot task copies counter into slot
// [R14] simultaneous start and stop leaves it halted
// [R15] clear, count, stop act within one cycle
// [R16] start may take more than one cycle
// [R17] tasks and matches are one-cycle pulses
// [R18] slots software writable, snapshot overrides write
//
// Our own choices: the placing of the registers and strobed register access.
`timescale 1ns/1ns
`include "tdtc_defs.vh"

module tdtc_timer #(
    parameter N_SLOTS     = 4,
    parameter START_DELAY = `TDTC_START_DELAY
) (
    input  wire                 ref_clk_i,
    input  wire                 arst_n_i,
    input  wire                 start_task_i,
    input  wire                 stop_task_i,
    input  wire                 count_task_i,
    input  wire                 clear_task_i,
    input  wire [N_SLOTS-1:0]   snap_task_i,
    input  wire [7:0]           addr_i,
    input  wire [31:0]          wr_data_i,
    input  wire                 wr_i,
    input  wire                 rd_i,
    output reg  [31:0]          rd_data_o,
    output reg  [N_SLOTS-1:0]   match_o,
    output reg                  running_o,
    output reg                  irq_o
);

    // state machine codes, one-hot
    localparam ST_IDLE  = 3'b001;
    localparam ST_ARM   = 3'b010;
    localparam ST_RUN   = 3'b100;

    reg  [2:0]          state_reg;
    reg  [2:0]          state_next;
    reg  [1:0]          arm_cnt_reg;
    reg                 mode_reg;
    reg  [1:0]          width_reg;
    reg  [3:0]          div_exp_reg;
    reg  [31:0]         count_reg;
    reg  [31:0]         count_next;
    reg  [N_SLOTS-1:0]  irq_stat_reg;
    reg  [N_SLOTS-1:0]  irq_en_reg;
    reg  [N_SLOTS-1:0]  irq_stat_next;
    reg  [N_SLOTS-1:0]  irq_en_next;
    reg  [31:0]         width_mask;
    reg                 inc;
    reg  [31:0]         rd_mux;
    wire                tick;
    wire [31:0]         inc_val;
    wire [N_SLOTS-1:0]  match_w;
    wire [N_SLOTS*32-1:0] slot_vals;
    wire                sw_start;
    wire                sw_stop;
    wire                sw_count;
    wire                sw_clear;
    wire                start_any;
    wire                stop_any;
    wire                count_any;
    wire                clear_any;
    wire                running;
    wire                ctrl_wr;
    wire                mode_wr;
    wire                width_wr;
    wire                divexp_wr;
    wire                irq_en_wr;
    wire                irq_clr_wr;
    integer             i;

    // one strobe per register so each process tests a single wire
    assign ctrl_wr    = wr_i && (addr_i == `TDTC_OFF_CTRL);
    assign mode_wr    = wr_i && (addr_i == `TDTC_OFF_MODE);
    assign width_wr   = wr_i && (addr_i == `TDTC_OFF_WIDTH);
    assign divexp_wr  = wr_i && (addr_i == `TDTC_OFF_DIVEXP);
    assign irq_en_wr  = wr_i && (addr_i == `TDTC_OFF_IRQ_EN);
    assign irq_clr_wr = wr_i && (addr_i == `TDTC_OFF_IRQ_CLR);

    // software task bits merge with the task pulse inputs
    assign sw_start  = ctrl_wr && wr_data_i[`TDTC_CTRL_START];
    assign sw_stop   = ctrl_wr && wr_data_i[`TDTC_CTRL_STOP];
    assign sw_count  = ctrl_wr && wr_data_i[`TDTC_CTRL_COUNT];
    assign sw_clear  = ctrl_wr && wr_data_i[`TDTC_CTRL_CLEAR];
    assign start_any = start_task_i | sw_start;
    assign stop_any  = stop_task_i | sw_stop;
    assign count_any = count_task_i | sw_count;
    assign clear_any = clear_task_i | sw_clear;
    assign running   = (state_reg == ST_RUN);

    // counting mode; software keeps it still while running
    always @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            mode_reg <= `TDTC_RST_MODE;
        end else if (mode_wr) begin
            mode_reg <= wr_data_i[0];
        end
    end

    // width select; software keeps it still while running
    always @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            width_reg <= `TDTC_RST_WIDTH;
        end else if (width_wr) begin
            width_reg <= wr_data_i[1:0]; // [R6] [R7]
        end
    end

    // divider exponent; values above the largest supported are clamped
    always @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            div_exp_reg <= `TDTC_RST_DIVEXP;
        end else if (divexp_wr) begin
            div_exp_reg <= (wr_data_i[3:0] > `TDTC_DIVEXP_MAX) ? `TDTC_DIVEXP_MAX : wr_data_i[3:0]; // [R7]
        end
    end

    // active low bits for the selected width
    always @* begin
        case (width_reg)
            `TDTC_WIDTH_8:  width_mask = 32'h0000_00ff;
            `TDTC_WIDTH_16: width_mask = 32'h0000_ffff;
            `TDTC_WIDTH_24: width_mask = 32'h00ff_ffff;
            `TDTC_WIDTH_32: width_mask = 32'hffff_ffff;
            default:        width_mask = 32'hffff_ffff;
        endcase
    end

    // run state: start waits out a short latency, stop wins at once
    always @* begin
        case (state_reg)
            ST_IDLE: begin
                if (start_any && !stop_any) begin
                    state_next = ST_ARM; // [R1]
                end else begin
                    state_next = ST_IDLE; // [R14]
                end
            end
            ST_ARM: begin
                if (stop_any) begin
                    state_next = ST_IDLE; // [R14] [R15]
                end else if (arm_cnt_reg == 2'd0) begin
                    state_next = ST_RUN; // [R16]
                end else begin
                    state_next = ST_ARM;
                end
            end
            ST_RUN: begin
                if (stop_any) begin
                    state_next = ST_IDLE; // [R1] [R15]
                end else begin
                    state_next = ST_RUN;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    // state register
    always @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_reg <= ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // arm countdown, reloaded whenever the machine is not arming
    always @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            arm_cnt_reg <= 2'd0;
        end else if (state_reg != ST_ARM) begin
            arm_cnt_reg <= START_DELAY[1:0] - 2'd1; // [R16]
        end else if (arm_cnt_reg != 2'd0) begin
            arm_cnt_reg <= arm_cnt_reg - 2'd1;
        end
    end

    // divided tick for tick mode
    tdtc_tick_div #(
        .DIV_W (10)
    ) u_div (
        .ref_clk_i (ref_clk_i),
        .arst_n_i  (arst_n_i),
        .run_i     (running && (mode_reg == `TDTC_MODE_TICK)),
        .restart_i (clear_any),
        .div_exp_i (div_exp_reg),
        .tick_o    (tick)
    );

    // increment source depends on mode; stop in the same cycle blocks it
    always @* begin
        if (mode_reg == `TDTC_MODE_TICK) begin
            inc = running && !stop_any && tick; // [R3] [R5]
        end else begin
            inc = running && !stop_any && count_any; // [R4] [R15]
        end
    end

    // wrap inside the active width, upward only
    assign inc_val = (count_reg + 32'h0000_0001) & width_mask; // [R2] [R8] [R6]

    // clear beats increment; both act at the next edge
    always @* begin
        if (clear_any) begin
            count_next = 32'h0000_0000; // [R9] [R15]
        end else if (inc) begin
            count_next = inc_val; // [R3] [R4]
        end else begin
            count_next = count_reg;
        end
    end

    always @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            count_reg <= 32'h0000_0000;
        end else begin
            count_reg <= count_next;
        end
    end

    // one slot per capture/compare value
    genvar g;
    generate
        for (g = 0; g < N_SLOTS; g = g + 1) begin : g_slot
            tdtc_slot u_slot (
                .ref_clk_i    (ref_clk_i),
                .arst_n_i     (arst_n_i),
                .wr_i         (wr_i && (addr_i == (`TDTC_OFF_SLOT0 + g))),
                .wr_data_i    (wr_data_i),
                .snap_i       (snap_task_i[g]),
                .count_i      (count_reg),
                .inc_i        (inc && !clear_any),
                .next_count_i (inc_val),
                .width_mask_i (width_mask),
                .value_o      (slot_vals[g*32 +: 32]),
                .match_o      (match_w[g])
            ); // [R11] [R13]
        end
    endgenerate

    // next interrupt enable, written as one word
    always @* begin
        if (irq_en_wr) begin
            irq_en_next = wr_data_i[N_SLOTS-1:0];
        end else begin
            irq_en_next = irq_en_reg;
        end
    end

    // next sticky status; a new event beats a clear in the same cycle
    always @* begin
        if (irq_clr_wr) begin
            irq_stat_next = (irq_stat_reg & ~wr_data_i[N_SLOTS-1:0]) | match_w; // [R11]
        end else begin
            irq_stat_next = irq_stat_reg | match_w;
        end
    end

    // match events leave as one-cycle pulses
    always @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            match_o <= {N_SLOTS{1'b0}};
        end else begin
            match_o <= match_w; // [R11] [R17]
        end
    end

    // running flag is registered from the next state, so it tracks the state register
    always @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            running_o <= 1'b0;
        end else begin
            running_o <= (state_next == ST_RUN); // [R1]
        end
    end

    // status, enable and interrupt move together, so no lag on a clear
    always @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            irq_stat_reg <= {N_SLOTS{1'b0}};
            irq_en_reg   <= {N_SLOTS{1'b0}};
            irq_o        <= 1'b0;
        end else begin
            irq_stat_reg <= irq_stat_next;
            irq_en_reg   <= irq_en_next;
            irq_o        <= |(irq_stat_next & irq_en_next);
        end
    end

    // read mux; unmapped addresses read zero
    always @* begin
        rd_mux = 32'h0000_0000;
        case (addr_i)
            `TDTC_OFF_MODE:     rd_mux[0] = mode_reg;
            `TDTC_OFF_WIDTH:    rd_mux[1:0] = width_reg;
            `TDTC_OFF_DIVEXP:   rd_mux[3:0] = div_exp_reg;
            `TDTC_OFF_STATUS:   rd_mux[0] = running;
            `TDTC_OFF_IRQ_STAT: rd_mux[N_SLOTS-1:0] = irq_stat_reg;
            `TDTC_OFF_IRQ_EN:   rd_mux[N_SLOTS-1:0] = irq_en_reg;
            `TDTC_OFF_COUNT:    rd_mux = count_reg;
            default: begin
                for (i = 0; i < N_SLOTS; i = i + 1) begin
                    if (addr_i == (`TDTC_OFF_SLOT0 + i)) begin
                        rd_mux = slot_vals[i*32 +: 32]; // [R18]
                    end
                end
            end
        endcase
    end

    // read data stands one cycle after the strobe only
    always @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rd_data_o <= 32'h0000_0000;
        end else if (rd_i) begin
            rd_data_o <= rd_mux;
        end else begin
            rd_data_o <= 32'h0000_0000;
        end
    end

endmodule

// File: tdtc_defs.vh
// tdtc_defs.vh: offsets, field positions, reset values and timing counts
// assumes inclusion by bare name from every design file of the timer block
`ifndef TDTC_DEFS_VH
`define TDTC_DEFS_VH

// register word addresses (byte address / 4)
`define TDTC_ADDR_W         8
`define TDTC_OFF_CTRL       8'h00
`define TDTC_OFF_MODE       8'h01
`define TDTC_OFF_WIDTH      8'h02
`define TDTC_OFF_DIVEXP     8'h03
`define TDTC_OFF_STATUS     8'h04
`define TDTC_OFF_IRQ_STAT   8'h05
`define TDTC_OFF_IRQ_EN     8'h06
`define TDTC_OFF_IRQ_CLR    8'h07
`define TDTC_OFF_COUNT      8'h08
`define TDTC_OFF_SLOT0      8'h10

// control register bit positions (write-one task bits)
`define TDTC_CTRL_START     0
`define TDTC_CTRL_STOP      1
`define TDTC_CTRL_COUNT     2
`define TDTC_CTRL_CLEAR     3

// mode encoding
`define TDTC_MODE_TICK      1'b0
`define TDTC_MODE_EVENT     1'b1

// width select encoding
`define TDTC_WIDTH_16       2'd0
`define TDTC_WIDTH_8        2'd1
`define TDTC_WIDTH_24       2'd2
`define TDTC_WIDTH_32       2'd3

// reset values
`define TDTC_RST_MODE       1'b0
`define TDTC_RST_WIDTH      2'd0
`define TDTC_RST_DIVEXP     4'h0
`define TDTC_DIVEXP_MAX     4'h9

// start latency in cycles of the high speed clock
`define TDTC_START_DELAY    2

`endif

// File: tdtc_tick_div.v
// tdtc_tick_div.v: power-of-two tick divider for the timer
// assumes one clock; divider exponent held stable while the timer runs
`timescale 1ns/1ns
`include "tdtc_defs.vh"

module tdtc_tick_div #(
    parameter DIV_W = 10
) (
    input  wire       ref_clk_i,
    input  wire       arst_n_i,
    input  wire       run_i,
    input  wire       restart_i,
    input  wire [3:0] div_exp_i,
    output reg        tick_o
);

    reg  [DIV_W-1:0] cnt_reg;
    wire [DIV_W-1:0] mask;

    // low bits selected by the exponent must all be one to tick
    assign mask = ~({DIV_W{1'b1}} << div_exp_i);

    // free count while running, one-cycle tick each 2^exp clocks
    always @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cnt_reg <= {DIV_W{1'b0}};
            tick_o  <= 1'b0;
        end else if (restart_i || !run_i) begin
            cnt_reg <= {DIV_W{1'b0}};
            tick_o  <= 1'b0;
        end else begin
            cnt_reg <= cnt_reg + {{(DIV_W-1){1'b0}}, 1'b1};
            tick_o  <= ((cnt_reg & mask) == mask);
        end
    end

endmodule

// File: tdtc_slot.v
// tdtc_slot.v: one capture/compare slot with its match event
// assumes counter and width mask come from the same clock domain
`timescale 1ns/1ns
`include "tdtc_defs.vh"

module tdtc_slot (
    input  wire        ref_clk_i,
    input  wire        arst_n_i,
    input  wire        wr_i,
    input  wire [31:0] wr_data_i,
    input  wire        snap_i,
    input  wire [31:0] count_i,
    input  wire        inc_i,
    input  wire [31:0] next_count_i,
    input  wire [31:0] width_mask_i,
    output reg  [31:0] value_o,
    output reg         match_o
);

    // snapshot wins over a software write in the same cycle
    always @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            value_o <= 32'h0000_0000;
        end else if (snap_i) begin
            value_o <= count_i; // [R13] [R18]
        end else if (wr_i) begin
            value_o <= wr_data_i; // [R18]
        end
    end

    // match only on an increment, only on the active low bits
    always @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            match_o <= 1'b0;
        end else begin
            match_o <= inc_i && ((next_count_i & width_mask_i) == (value_o & width_mask_i)); // [R10] [R12] [R17]
        end
    end

endmodule

// File: tdtc_asserts.sv
// tdtc_asserts.sv: port checks for the task driven timer
// assumes bind onto tdtc_timer; one clock, async low reset
`timescale 1ns/1ns
module tdtc_chk #(
    parameter N_SLOTS = 4
) (
    input wire logic               ref_clk_i,
    input wire logic               arst_n_i,
    input wire logic               start_task_i,
    input wire logic               stop_task_i,
    input wire logic               wr_i,
    input wire logic               rd_i,
    input wire logic [31:0]        rd_data_o,
    input wire logic [N_SLOTS-1:0] match_o,
    input wire logic               running_o,
    input wire logic               irq_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!arst_n_i);
    // start and stop tasks
    a_stop_halts: assert property (stop_task_i |=> !running_o [*2])
        else $error("running after stop");
    a_stop_wins: assert property (start_task_i && stop_task_i |=> !running_o [*3])
        else $error("start beat stop");
    a_start_lands: assert property (start_task_i && !stop_task_i && !running_o
        |-> ##[1:4] (running_o || $past(stop_task_i)))
        else $error("start never took effect");
    a_halt_cause: assert property ($fell(running_o) |-> $past(stop_task_i) || $past(wr_i))
        else $error("halted without stop");
    // match events
    a_match_single: assert property (!(|(match_o & $past(match_o))))
        else $error("match longer than one cycle");
    a_match_needs_run: assert property (|match_o |-> $past(running_o) || $past(running_o, 2))
        else $error("match while halted");
    // register read port and interrupt
    a_read_idle: assert property (!$past(rd_i) |-> rd_data_o == 32'h0)
        else $error("read data outside its cycle");
    a_irq_source: assert property ($rose(irq_o)
        |-> (|match_o) || $past(|match_o) || $past(|match_o, 2) || $past(wr_i) || $past(wr_i, 2))
        else $error("interrupt without cause");
    c_run: cover property ($rose(running_o));
    c_match: cover property (|match_o);
    c_irq: cover property ($rose(irq_o));
endmodule
bind tdtc_timer tdtc_chk #(.N_SLOTS(N_SLOTS)) u_chk (
    .ref_clk_i   (ref_clk_i),
    .arst_n_i    (arst_n_i),
    .start_task_i(start_task_i),
    .stop_task_i (stop_task_i),
    .wr_i        (wr_i),
    .rd_i        (rd_i),
    .rd_data_o   (rd_data_o),
    .match_o     (match_o),
    .running_o   (running_o),
    .irq_o       (irq_o)
);

// File: tdtc_src.sv
// tdtc_src.sv: on-chip count task source and match event sink
// assumes one clock; go_i is a one-cycle request
`timescale 1ns/1ns
module tdtc_src (
    input  wire logic       ref_clk_i,
    input  wire logic       arst_n_i,
    input  wire logic       go_i,
    input  wire logic [8:0] num_i,
    input  wire logic       slow_i,
    input  wire logic [1:0] match_i,
    output logic            count_task_o,
    output logic            busy_o,
    output logic [7:0]      hits_o
);
    logic [8:0] left_reg;
    logic       gap_reg;
    // count pulses back to back, or with a gap when slow
    always @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            left_reg     <= 9'h0;
            gap_reg      <= 1'b0;
            count_task_o <= 1'b0;
            hits_o       <= 8'h0;
        end else begin
            count_task_o <= 1'b0;
            gap_reg      <= 1'b0;
            if (go_i) begin
                left_reg <= num_i;
            end else if (left_reg != 9'h0 && !gap_reg) begin
                count_task_o <= 1'b1;
                left_reg     <= left_reg - 9'h1;
                gap_reg      <= slow_i;
            end
            // tally events of the first two slots
            if (|match_i) begin
                hits_o <= hits_o + 8'h1;
            end
        end
    end
    assign busy_o = (left_reg != 9'h0) | count_task_o;
endmodule

// File: tdtc_timer_test.sv
// tdtc_timer_test.sv: self-checking bench for the task driven timer
// assumes tdtc_chk bound in and tdtc_src issuing count tasks
`timescale 1ns/1ns
`include "tdtc_defs.vh"
module tdtc_timer_test;
    logic        ref_clk_i = 1'b0;
    logic        arst_n_i  = 1'b0;
    logic [2:0]  tk        = 3'h0;
    logic [3:0]  snap      = 4'h0;
    logic [7:0]  addr      = 8'h0;
    logic [31:0] wdat      = 32'h0;
    logic        wr        = 1'b0;
    logic        rd        = 1'b0;
    logic        go        = 1'b0;
    logic        slow      = 1'b0;
    logic [8:0]  num       = 9'h0;
    wire  [31:0] rdat;
    wire  [3:0]  match;
    wire         running, irq, cnt_task, busy;
    wire  [7:0]  hits;
    logic [31:0] d, r;
    logic [7:0]  rst_a [9] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h08, 8'h10, 8'h3f};
    int          n_mismatch = 0;
    int          total_checks = 0;
    int          w, k;
    always #4 ref_clk_i = ~ref_clk_i;
    tdtc_timer i_dut (
        .ref_clk_i   (ref_clk_i),
        .arst_n_i    (arst_n_i),
        .start_task_i(tk[0]),
        .stop_task_i (tk[1]),
        .count_task_i(cnt_task),
        .clear_task_i(tk[2]),
        .snap_task_i (snap),
        .addr_i      (addr),
        .wr_data_i   (wdat),
        .wr_i        (wr),
        .rd_i        (rd),
        .rd_data_o   (rdat),
        .match_o     (match),
        .running_o   (running),
        .irq_o       (irq)
    );
    tdtc_src u_src (
        .ref_clk_i   (ref_clk_i),
        .arst_n_i    (arst_n_i),
        .go_i        (go),
        .num_i       (num),
        .slow_i      (slow),
        .match_i     (match[1:0]),
        .count_task_o(cnt_task),
        .busy_o      (busy),
        .hits_o      (hits)
    );
    // comparisons
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk_rng(input logic [31:0] got, input int lo, input int hi);
        total_checks++;
        if ($isunknown(got) || got < lo || got > hi) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got %0d out of range", $time, got);
        end
    endtask
    // register port cycles
    task automatic wreg(input logic [7:0] a, input logic [31:0] v);
        @(posedge ref_clk_i);
        addr <= a;
        wdat <= v;
        wr <= 1'b1;
        @(posedge ref_clk_i);
        wr <= 1'b0;
    endtask
    task automatic rget(input logic [7:0] a);
        @(posedge ref_clk_i);
        addr <= a;
        rd <= 1'b1;
        @(posedge ref_clk_i);
        rd <= 1'b0;
        #1 d = rdat;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        rget(a);
        chk(d, exp);
    endtask
    // expected count inside the 8 bit width
    function automatic logic [31:0] wrap8(input int v);
        return v & 32'hff;
    endfunction
    // task pulses and counting through the source model
    task automatic pulse(input logic [2:0] v);
        @(posedge ref_clk_i);
        tk <= v;
        @(posedge ref_clk_i);
        tk <= 3'h0;
    endtask
    task automatic cnt(input int n);
        @(posedge ref_clk_i);
        go <= 1'b1;
        num <= n[8:0];
        slow <= $urandom_range(1, 0);
        @(posedge ref_clk_i);
        go <= 1'b0;
        #1 k = 0;
        while (busy && k < 600) begin
            @(posedge ref_clk_i);
            #1 k++;
        end
        chk({31'h0, busy}, 32'h0);
        repeat (3) @(posedge ref_clk_i);
        #1;
    endtask
    task automatic start_wait;
        pulse(3'h1);
        #1 k = 0;
        while (running !== 1'b1 && k < 10) begin
            @(posedge ref_clk_i);
            #1 k++;
        end
        chk({31'h0, running}, 32'h1);
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge ref_clk_i);
        n_mismatch++;
        $display("MISMATCH t=%0t watchdog expired", $time);
        wrap_up;
    end
    initial begin
        void'($urandom(32'hf491));
        w = $urandom_range(200, 1);
        r = $urandom;
        repeat (4) @(posedge ref_clk_i);
        arst_n_i <= 1'b1;
        foreach (rst_a[i]) rchk(rst_a[i], 32'h0);
        // event mode, 8 bit width, divider set high while halted
        wreg(`TDTC_OFF_MODE, 32'h1);
        wreg(`TDTC_OFF_WIDTH, 32'h1);
        wreg(`TDTC_OFF_DIVEXP, 32'h9);
        wreg(`TDTC_OFF_SLOT0, w);
        wreg(`TDTC_OFF_SLOT0 + 8'h1, 32'h1200 | (w + 3));
        wreg(`TDTC_OFF_IRQ_EN, 32'h1);
        cnt(5);
        rchk(`TDTC_OFF_COUNT, 32'h0);
        start_wait;
        cnt(w - 1);
        rchk(`TDTC_OFF_COUNT, wrap8(w - 1));
        chk(hits, 32'h0);
        cnt(1);
        chk(hits, 32'h1);
        chk({31'h0, irq}, 32'h1);
        cnt(3);
        chk(hits, 32'h2);
        rchk(`TDTC_OFF_IRQ_STAT, 32'h3);
        // mask, unmask, clear the interrupt
        wreg(`TDTC_OFF_IRQ_EN, 32'h0);
        repeat (2) @(posedge ref_clk_i);
        #1 chk({31'h0, irq}, 32'h0);
        wreg(`TDTC_OFF_IRQ_EN, 32'h1);
        repeat (2) @(posedge ref_clk_i);
        #1 chk({31'h0, irq}, 32'h1);
        wreg(`TDTC_OFF_IRQ_CLR, 32'h1);
        repeat (2) @(posedge ref_clk_i);
        #1 chk({31'h0, irq}, 32'h0);
        rchk(`TDTC_OFF_IRQ_STAT, 32'h2);
        // overflow wraps within the 8 bit width
        cnt(256 - (w + 3));
        rchk(`TDTC_OFF_COUNT, 32'h0);
        cnt(7);
        pulse(3'h2);
        cnt(4);
        rchk(`TDTC_OFF_COUNT, 32'h7);
        // snapshot wins over a software write in the same cycle
        @(posedge ref_clk_i);
        snap <= 4'h4;
        addr <= `TDTC_OFF_SLOT0 + 8'h2;
        wdat <= r;
        wr <= 1'b1;
        @(posedge ref_clk_i);
        snap <= 4'h0;
        wr <= 1'b0;
        rchk(`TDTC_OFF_SLOT0 + 8'h2, 32'h7);
        wreg(`TDTC_OFF_SLOT0 + 8'h3, r);
        rchk(`TDTC_OFF_SLOT0 + 8'h3, r);
        pulse(3'h4);
        rchk(`TDTC_OFF_COUNT, 32'h0);
        pulse(3'h3);
        repeat (5) @(posedge ref_clk_i);
        #1 chk({31'h0, running}, 32'h0);
        // tick mode, one tick every fourth clock
        wreg(`TDTC_OFF_MODE, 32'h0);
        wreg(`TDTC_OFF_WIDTH, 32'h0);
        wreg(`TDTC_OFF_DIVEXP, 32'h2);
        start_wait;
        cnt(3);
        repeat (36) @(posedge ref_clk_i);
        pulse(3'h2);
        @(posedge ref_clk_i);
        rchk(`TDTC_OFF_STATUS, 32'h0);
        rget(`TDTC_OFF_COUNT);
        chk_rng(d, 9, 12);
        wrap_up;
    end
endmodule
